// ### verilog/rmc_top.sv
// Chip reset, strap capture, slow clock selection and operating mode control.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module rmc_top #(
   parameter int EBI_W = 24,
   parameter int BSR_W = 8,
   parameter int SLOW_HALF = rmc_pkg::SLOW_HALF_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic mode_sel_bit0,
   input wire logic mode_sel_bit1,
   input wire logic osc_in,
   input wire logic ext_reset_n,
   input wire logic test_reset_n,
   input wire logic wdt_reset_req,
   input wire logic boot_width_strap,
   input wire logic tristate_strap_n,
   input wire logic tap_select,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic ice_tdo,
   output logic tdo,
   output logic tdo_oe,
   output logic ice_sel,
   input wire logic [BSR_W-1:0] bscan_pin_in,
   output logic [BSR_W-1:0] bscan_pin_out,
   output logic bscan_extest,
   input wire logic [EBI_W-1:0] ebi_addr_in,
   output logic [EBI_W-1:0] ebi_addr_out,
   output logic slow_clock,
   output logic clock_out_pin,
   output logic clock_out_oe,
   output rmc_pkg::rmc_mode_e op_mode,
   output rmc_pkg::rmc_strap_s strap,
   output rmc_pkg::rmc_rst_s rst,
   output logic periph_clk_en,
   output logic pad_oe_allow,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import rmc_pkg::*;

   // ----------------------------------------
   // Mode decode and slow clock source
   // ----------------------------------------
   rmc_mode_e mode_reg, mode_next;
   logic [15:0] div_reg, div_next;
   logic osc_int_reg, osc_int_next;
   logic slow_clock_reg, slow_clock_next;
   logic slow_src, slow_rise;

   always_comb begin
      mode_next = rmc_mode_e'({mode_sel_bit1, mode_sel_bit0});
      osc_int_next = osc_int_reg;
      div_next = div_reg + 16'h0001;
      if (div_reg == 16'(SLOW_HALF - 1)) begin
         div_next = 16'h0000;
         osc_int_next = ~osc_int_reg;
      end
      slow_src = (mode_reg == MODE_EXTCLK) ? osc_in : osc_int_reg;
      slow_clock_next = slow_src;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_reg <= MODE_NORMAL;
         div_reg <= 16'h0000;
         osc_int_reg <= 1'b0;
         slow_clock_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         div_reg <= div_next;
         osc_int_reg <= osc_int_next;
         slow_clock_reg <= slow_clock_next;
      end
   end

   assign slow_rise = slow_src & ~slow_clock_reg;
   assign slow_clock = slow_clock_reg;
   assign op_mode = mode_reg;

   // ----------------------------------------
   // Reset generation
   // ----------------------------------------
   logic ext_clr, ext_rel, sys_rst;
   logic [3:0] wdt_reg, wdt_next;
   logic wsrc_reg, wsrc_next;

   // Pin assertion clears the synchroniser at once; only release waits for the slow clock.
   assign ext_clr = reset | ~ext_reset_n;

   rmc_sync #(.STAGES(SYNC_STAGES)) u_sync (
      .ref_clk(ref_clk),
      .clr(ext_clr),
      .tick(slow_rise),
      .released(ext_rel)
   );

   always_comb begin
      wdt_next = wdt_reg;
      wsrc_next = wsrc_reg;
      if (!ext_rel) begin
         wdt_next = 4'h0;
         wsrc_next = 1'b0;
      end else if (wdt_reset_req && wdt_reg == 4'h0) begin
         wdt_next = 4'(WDT_HOLD_SLOW);
         wsrc_next = 1'b1;
      end else if (slow_rise && wdt_reg != 4'h0) begin
         wdt_next = wdt_reg - 4'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wdt_reg <= 4'h0;
         wsrc_reg <= 1'b0;
      end else begin
         wdt_reg <= wdt_next;
         wsrc_reg <= wsrc_next;
      end
   end

   assign sys_rst = ~ext_rel | (wdt_reg != 4'h0);

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   logic ext_n_reg;
   logic [STRAP_WIN_SLOW-1:0] boot_h_reg, boot_h_next, tri_h_reg, tri_h_next;
   rmc_strap_s strap_reg, strap_next;

   // Straps are held across watchdog resets because only the pin edge latches them.
   always_comb begin
      boot_h_next = boot_h_reg;
      tri_h_next = tri_h_reg;
      strap_next = strap_reg;
      if (!ext_reset_n && slow_rise) begin
         boot_h_next = {boot_h_reg[STRAP_WIN_SLOW-2:0], boot_width_strap};
         tri_h_next = {tri_h_reg[STRAP_WIN_SLOW-2:0], tristate_strap_n};
      end
      if (!ext_n_reg && ext_reset_n) begin
         strap_next.boot_8bit = boot_h_reg[0];
         strap_next.tristate = ~|tri_h_reg;
         strap_next.tap_sel = tap_select;
         boot_h_next = '1;
         tri_h_next = '1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ext_n_reg <= 1'b1;
         boot_h_reg <= '1;
         tri_h_reg <= '1;
         strap_reg <= '0;
      end else begin
         ext_n_reg <= ext_reset_n;
         boot_h_reg <= boot_h_next;
         tri_h_reg <= tri_h_next;
         strap_reg <= strap_next;
      end
   end

   assign strap = strap_reg;
   assign pad_oe_allow = ~strap_reg.tristate;

   // ----------------------------------------
   // Reset side effects
   // ----------------------------------------
   logic [EBI_W-1:0] addr_reg, addr_next;

   always_comb begin
      addr_next = sys_rst ? '0 : ebi_addr_in;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         addr_reg <= '0;
      end else begin
         addr_reg <= addr_next;
      end
   end

   assign ebi_addr_out = sys_rst ? '0 : addr_reg;

   // One process drives the whole reset bundle, so the port keeps a single driver.
   always_comb begin
      rst.periph = sys_rst;
      rst.cpu_fetch_zero = sys_rst;
      rst.pio_input = sys_rst;
      rst.tap_ice = ~test_reset_n & ~strap_reg.tap_sel;
      rst.tap_bscan = ~test_reset_n & strap_reg.tap_sel;
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   logic [2:0] ctrl_reg, ctrl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] stat_word;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[STAT_MODE_LSB +: 2] = mode_reg;
      stat_word[STAT_BOOT] = strap_reg.boot_8bit;
      stat_word[STAT_TRI] = strap_reg.tristate;
      stat_word[STAT_TAPSEL] = strap_reg.tap_sel;
      stat_word[STAT_WDT_SRC] = wsrc_reg;
      ctrl_next = ctrl_reg;
      if (sys_rst) begin
         ctrl_next = CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_next = reg_wdata[2:0];
      end
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: rdata_next = {29'h0, ctrl_reg};
            ADDR_STAT: rdata_next = stat_word;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= CTRL_RESET;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign periph_clk_en = ~sys_rst & ctrl_reg[CTRL_PCLK_EN];

   // ----------------------------------------
   // Clock output pin
   // ----------------------------------------
   logic cko_reg, cko_next;

   always_comb begin
      cko_next = ctrl_reg[CTRL_CLKOUT_GPIO] ? ctrl_reg[CTRL_GPIO_LEVEL] : slow_src;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cko_reg <= 1'b0;
      end else begin
         cko_reg <= cko_next;
      end
   end

   assign clock_out_pin = cko_reg;
   assign clock_out_oe = ~strap_reg.tristate;

   // ----------------------------------------
   // Debug port routing
   // ----------------------------------------
   logic tck_reg;
   logic bs_tdo, bs_oe;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tck_reg <= 1'b0;
      end else begin
         tck_reg <= tck;
      end
   end

   rmc_tap #(.BSR_W(BSR_W)) u_tap (
      .ref_clk(ref_clk),
      .reset(reset),
      .tap_rst(rst.tap_bscan),
      .tck_rise(tck & ~tck_reg),
      .tck_fall(~tck & tck_reg),
      .tms(tms),
      .tdi(tdi),
      .pin_in(bscan_pin_in),
      .tdo(bs_tdo),
      .tdo_oe(bs_oe),
      .pin_out(bscan_pin_out),
      .extest(bscan_extest)
   );

   assign ice_sel = ~mode_reg[1];
   assign tdo = ice_sel ? ice_tdo : bs_tdo;
   assign tdo_oe = ice_sel ? 1'b1 : bs_oe;
endmodule : rmc_top

// ### verilog/rmc_pkg.sv
// Constants, types and encodings shared by the reset and mode control block.
package rmc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int REF_CLK_HZ = 40_000_000;
   localparam int SLOW_CLK_HZ = 32_768;
   localparam int SLOW_HALF_CYC = REF_CLK_HZ / (2 * SLOW_CLK_HZ);
   localparam int STRAP_WIN_SLOW = 10;
   localparam int WDT_HOLD_SLOW = 10;
   localparam int SYNC_STAGES = 2;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam int CTRL_CLKOUT_GPIO = 0;
   localparam int CTRL_GPIO_LEVEL = 1;
   localparam int CTRL_PCLK_EN = 2;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_BOOT = 2;
   localparam int STAT_TRI = 3;
   localparam int STAT_TAPSEL = 4;
   localparam int STAT_WDT_SRC = 5;
   // ----------------------------------------
   // Boundary scan
   // ----------------------------------------
   localparam int IR_W = 4;
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_EXTCLK = 2'b01,
      MODE_BSCAN = 2'b10,
      MODE_TEST = 2'b11
   } rmc_mode_e;
   typedef struct packed {
      logic boot_8bit;
      logic tristate;
      logic tap_sel;
   } rmc_strap_s;
   typedef struct packed {
      logic periph;
      logic cpu_fetch_zero;
      logic pio_input;
      logic tap_ice;
      logic tap_bscan;
   } rmc_rst_s;
endpackage : rmc_pkg

// ### verilog/rmc_sync.sv
// Reset release synchroniser advancing on slow clock ticks.
`timescale 1ns/1ps
module rmc_sync #(
   parameter int STAGES = 2
) (
   input wire logic ref_clk,
   input wire logic clr,
   input wire logic tick,
   output logic released
);
   logic [STAGES-1:0] sh_reg;
   logic [STAGES-1:0] sh_next;

   // The first stage feeds only the second, so a late release cannot glitch the output.
   always_comb begin
      sh_next = sh_reg;
      if (tick) begin
         sh_next = {sh_reg[STAGES-2:0], 1'b1};
      end
   end

   always_ff @(posedge ref_clk or posedge clr) begin
      if (clr) begin
         sh_reg <= '0;
      end else begin
         sh_reg <= sh_next;
      end
   end

   assign released = sh_reg[STAGES-1];
endmodule : rmc_sync

// ### verilog/rmc_tap.sv
// Boundary scan test access port with SAMPLE, EXTEST and BYPASS.
`timescale 1ns/1ps
module rmc_tap #(
   parameter int BSR_W = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic tap_rst,
   input wire logic tck_rise,
   input wire logic tck_fall,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [BSR_W-1:0] pin_in,
   output logic tdo,
   output logic tdo_oe,
   output logic [BSR_W-1:0] pin_out,
   output logic extest
);
   import rmc_pkg::*;
   typedef enum logic [3:0] {
      TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2, SH_DR = 4'h6, EX1_DR = 4'h7,
      PAU_DR = 4'h5, EX2_DR = 4'h4, UPD_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF,
      SH_IR = 4'hE, EX1_IR = 4'hA, PAU_IR = 4'hB, EX2_IR = 4'h9, UPD_IR = 4'h8
   } rmc_tap_e;
   rmc_tap_e st_reg, st_next, st_adv;
   logic [IR_W-1:0] ir_reg, ir_next, irs_reg, irs_next;
   logic [BSR_W-1:0] dr_reg, dr_next, out_reg, out_next;
   logic byp_reg, byp_next, tdo_reg, tdo_next, oe_reg, oe_next;
   logic is_byp;

   always_comb begin
      unique case (st_reg)
         TLR: st_adv = tms ? TLR : RTI;
         RTI: st_adv = tms ? SEL_DR : RTI;
         SEL_DR: st_adv = tms ? SEL_IR : CAP_DR;
         CAP_DR: st_adv = tms ? EX1_DR : SH_DR;
         SH_DR: st_adv = tms ? EX1_DR : SH_DR;
         EX1_DR: st_adv = tms ? UPD_DR : PAU_DR;
         PAU_DR: st_adv = tms ? EX2_DR : PAU_DR;
         EX2_DR: st_adv = tms ? UPD_DR : SH_DR;
         UPD_DR: st_adv = tms ? SEL_DR : RTI;
         SEL_IR: st_adv = tms ? TLR : CAP_IR;
         CAP_IR: st_adv = tms ? EX1_IR : SH_IR;
         SH_IR: st_adv = tms ? EX1_IR : SH_IR;
         EX1_IR: st_adv = tms ? UPD_IR : PAU_IR;
         PAU_IR: st_adv = tms ? EX2_IR : PAU_IR;
         EX2_IR: st_adv = tms ? UPD_IR : SH_IR;
         UPD_IR: st_adv = tms ? SEL_DR : RTI;
      endcase
   end

   // Unknown opcodes fall back to the one-bit bypass path.
   assign is_byp = (ir_reg != IR_EXTEST) && (ir_reg != IR_SAMPLE);

   always_comb begin
      st_next = st_reg;
      ir_next = ir_reg;
      irs_next = irs_reg;
      dr_next = dr_reg;
      out_next = out_reg;
      byp_next = byp_reg;
      tdo_next = tdo_reg;
      oe_next = oe_reg;
      if (tap_rst) begin
         st_next = TLR;
         ir_next = IR_BYPASS;
      end else if (tck_rise) begin
         st_next = st_adv;
         unique case (st_reg)
            TLR: ir_next = IR_BYPASS;
            CAP_DR: begin
               byp_next = 1'b0;
               dr_next = pin_in;
            end
            SH_DR: begin
               byp_next = tdi;
               dr_next = {tdi, dr_reg[BSR_W-1:1]};
            end
            UPD_DR: out_next = (ir_reg == IR_EXTEST) ? dr_reg : out_reg;
            CAP_IR: irs_next = IR_CAPTURE;
            SH_IR: irs_next = {tdi, irs_reg[IR_W-1:1]};
            UPD_IR: ir_next = irs_reg;
            default: ;
         endcase
      end else if (tck_fall) begin
         oe_next = (st_reg == SH_DR) || (st_reg == SH_IR);
         tdo_next = (st_reg == SH_IR) ? irs_reg[0] : (is_byp ? byp_reg : dr_reg[0]);
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_reg <= TLR;
         ir_reg <= IR_BYPASS;
         irs_reg <= '0;
         dr_reg <= '0;
         out_reg <= '0;
         byp_reg <= 1'b0;
         tdo_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ir_reg <= ir_next;
         irs_reg <= irs_next;
         dr_reg <= dr_next;
         out_reg <= out_next;
         byp_reg <= byp_next;
         tdo_reg <= tdo_next;
         oe_reg <= oe_next;
      end
   end

   assign tdo = tdo_reg;
   assign tdo_oe = oe_reg;
   assign pin_out = out_reg;
   assign extest = (ir_reg == IR_EXTEST);
endmodule : rmc_tap

// ### sim/rmc_top_assertions.sv
// Concurrent checks on the ports of the reset and mode control block.
`timescale 1ns/1ps
module rmc_chk
   import rmc_pkg::*;
#(
   parameter int EBI_W = 24,
   parameter int BSR_W = 8,
   parameter int SLOW_HALF = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic mode_sel_bit0,
   input wire logic mode_sel_bit1,
   input wire logic ext_reset_n,
   input wire logic test_reset_n,
   input wire logic boot_width_strap,
   input wire logic tap_select,
   input wire logic ice_sel,
   input wire logic [EBI_W-1:0] ebi_addr_out,
   input wire logic slow_clock,
   input wire logic clock_out_pin,
   input wire logic clock_out_oe,
   input wire rmc_pkg::rmc_mode_e op_mode,
   input wire rmc_pkg::rmc_strap_s strap,
   input wire rmc_pkg::rmc_rst_s rst,
   input wire logic periph_clk_en,
   input wire logic pad_oe_allow
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // ----------------
   // Properties
   // ----------------
   // Release waits for slow clock rises, so internal reset outlasts the pin by several cycles.
   sequence s_held;
      rst.periph [*4];
   endsequence
   sequence s_freed;
      ##[1:40] !rst.periph;
   endsequence
   AST_MODE_DECODE:
      assert property (!$past(reset) |-> op_mode == $past({mode_sel_bit1, mode_sel_bit0}))
      else $error("Operating mode does not follow the mode pins.");
   AST_ICE_ROUTE:
      assert property (ice_sel == !op_mode[1])
      else $error("Debug port routing disagrees with the mode.");
   AST_CLKOUT_COPY:
      assert property (!ext_reset_n && !$past(ext_reset_n) && !$past(ext_reset_n, 2)
         |-> clock_out_pin == slow_clock)
      else $error("Clock output is not a copy of the slow clock in reset.");
   AST_RESET_SIDE:
      assert property (rst.cpu_fetch_zero == rst.periph && rst.pio_input == rst.periph)
      else $error("Reset side effects are not applied together.");
   AST_EBI_LOW:
      assert property (rst.periph |-> ebi_addr_out == '0)
      else $error("Bus address is not low during reset.");
   AST_PCLK_OFF:
      assert property (rst.periph |-> !periph_clk_en)
      else $error("Peripheral clock runs during reset.");
   AST_ASYNC_ENTRY:
      assert property (!ext_reset_n |-> rst.periph)
      else $error("External reset did not enter at once.");
   AST_SYNC_RELEASE:
      assert property ($rose(ext_reset_n) |-> s_held ##0 s_freed)
      else $error("Reset release is not synchronised to the slow clock.");
   AST_STRAP_LATCH:
      assert property ($rose(ext_reset_n) |-> ##2 strap.tap_sel == $past(tap_select, 2)
         && strap.boot_8bit == $past(boot_width_strap, 2))
      else $error("Straps were not latched at reset release.");
   AST_STRAP_HOLD:
      assert property (ext_reset_n && $past(ext_reset_n) && $past(ext_reset_n, 2)
         && $past(ext_reset_n, 3) |-> $stable(strap))
      else $error("Straps changed without an external reset release.");
   AST_TAP_RESET:
      assert property (rst.tap_bscan == (!test_reset_n && strap.tap_sel)
         && rst.tap_ice == (!test_reset_n && !strap.tap_sel))
      else $error("Test port reset does not follow the test reset pin.");
   AST_TRISTATE:
      assert property (clock_out_oe == !strap.tristate && pad_oe_allow == !strap.tristate)
      else $error("Output drivers disagree with the latched tristate mode.");
endmodule : rmc_chk
bind rmc_top rmc_chk #(.EBI_W(EBI_W), .BSR_W(BSR_W), .SLOW_HALF(SLOW_HALF)) u_chk (
   .ref_clk, .reset, .mode_sel_bit0, .mode_sel_bit1, .ext_reset_n, .test_reset_n,
   .boot_width_strap, .tap_select, .ice_sel, .ebi_addr_out, .slow_clock, .clock_out_pin,
   .clock_out_oe, .op_mode, .strap, .rst, .periph_clk_en, .pad_oe_allow);

// ### sim/rmc_board.sv
// Board model: reset supervisor, strap resistors, probe test reset and external oscillator.
`timescale 1ns/1ps
module rmc_board (
   input wire logic ref_clk,
   input wire logic osc_run,
   output logic ext_reset_n,
   output logic test_reset_n,
   output logic boot_width_strap,
   output logic tristate_strap_n,
   output logic tap_select,
   output logic osc_in
);
   initial begin
      ext_reset_n = 1'b0;
      test_reset_n = 1'b0;
      boot_width_strap = 1'b1;
      tristate_strap_n = 1'b1;
      tap_select = 1'b0;
      osc_in = 1'b0;
   end
   // The external oscillator stands still when stopped, so a bypass can be seen at once.
   always #125 if (osc_run) osc_in = ~osc_in;
   task automatic full_reset(input int slow_cyc, input logic tri_n, input logic boot,
         input logic tsel);
      @(posedge ref_clk);
      ext_reset_n <= 1'b0;
      test_reset_n <= 1'b0;
      tristate_strap_n <= tri_n;
      boot_width_strap <= boot;
      tap_select <= tsel;
      // Twelve reference cycles cover one slow cycle from either clock source.
      repeat (slow_cyc * 12) @(posedge ref_clk);
      ext_reset_n <= 1'b1;
      test_reset_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      tristate_strap_n <= 1'b1;
      boot_width_strap <= ~boot;
   endtask : full_reset
   task automatic set_trst(input logic lvl);
      @(posedge ref_clk);
      test_reset_n <= lvl;
   endtask : set_trst
endmodule : rmc_board

// ### sim/test_reset_mode_control.sv
// Self-checking bench for the reset and mode control block.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
   $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); end end
module test_reset_mode_control;
   import rmc_pkg::*;
   localparam int HALF = 4;
   localparam logic [10:0] IR_SEQ = 11'h306;
   localparam logic [7:0] DR_IN = 8'h5C;
   logic ref_clk, reset, mode_sel_bit0, mode_sel_bit1, osc_in, ext_reset_n, test_reset_n;
   logic wdt_reset_req, boot_width_strap, tristate_strap_n, tap_select, ice_tdo, tdo, ice_sel;
   logic osc_run, slow_clock, clock_out_pin, clock_out_oe, periph_clk_en, pad_oe_allow;
   logic reg_wr, reg_rd, tck, tms, tdi, tdo_oe, bscan_extest;
   logic [7:0] bscan_pin_in, bscan_pin_out;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [23:0] ebi_addr_in, ebi_addr_out;
   rmc_mode_e op_mode;
   rmc_strap_s strap;
   rmc_rst_s rst;
   int failures = 0, check_count = 0, m, i, highs;
   rmc_top #(.SLOW_HALF(HALF)) DUT (
      .ref_clk, .reset, .mode_sel_bit0, .mode_sel_bit1, .osc_in, .ext_reset_n,
      .test_reset_n, .wdt_reset_req, .boot_width_strap, .tristate_strap_n, .tap_select,
      .tck, .tms, .tdi, .ice_tdo, .tdo, .tdo_oe, .ice_sel,
      .bscan_pin_in, .bscan_pin_out, .bscan_extest, .ebi_addr_in, .ebi_addr_out,
      .slow_clock, .clock_out_pin, .clock_out_oe, .op_mode, .strap, .rst, .periph_clk_en,
      .pad_oe_allow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   rmc_board board (.ref_clk, .osc_run, .ext_reset_n, .test_reset_n, .boot_width_strap,
      .tristate_strap_n, .tap_select, .osc_in);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Bounded wait, since a stuck release would otherwise hang the run.
   task automatic wait_release();
      for (i = 0; i < 400 && rst.periph !== 1'b0; i++) @(posedge ref_clk);
      if (rst.periph !== 1'b0) begin
         failures++;
         print_verdict();
      end
      @(posedge ref_clk);
   endtask : wait_release
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : reg_write
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
      `CHK(rd, e)
      @(posedge ref_clk);
   endtask : rd_chk
   // One test clock pulse: rise seen at the first edge, fall at the second.
   task automatic tck_bit(input logic ms, input logic di);
      tms <= ms;
      tdi <= di;
      tck <= 1'b1;
      @(posedge ref_clk);
      tck <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : tck_bit
   // ----------------
   // Scenarios
   // ----------------
   initial begin
      {reset, mode_sel_bit0, mode_sel_bit1, wdt_reset_req, ice_tdo, reg_wr, reg_rd} = 7'h40;
      {tck, tms, tdi} = 3'h2;
      bscan_pin_in = 8'h96;
      osc_run = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      ebi_addr_in = 24'hA5_5A5A;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      for (m = 0; m < 4; m++) begin
         mode_sel_bit1 <= m[1];
         mode_sel_bit0 <= m[0];
         board.full_reset(12, 1'b1, 1'b1, 1'b0);
         wait_release();
         `CHK(op_mode, rmc_mode_e'(m[1:0]))
         `CHK(ice_sel, ~m[1])
         if (m == 2) begin
            for (i = 0; i < 11; i++) tck_bit(IR_SEQ[i], 1'b0);
            `CHK(bscan_extest, 1'b1)
            tck_bit(1'b1, 1'b0);
            tck_bit(1'b0, 1'b0);
            tck_bit(1'b0, 1'b0);
            `CHK(tdo_oe, 1'b1)
            for (i = 0; i < 8; i++) begin
               rd[i] = tdo;
               tck_bit(i == 7, DR_IN[i]);
            end
            tck_bit(1'b1, 1'b0);
            tck_bit(1'b0, 1'b0);
            `CHK(rd[7:0], 8'h96)
            `CHK(bscan_pin_out, DR_IN)
         end
      end
      mode_sel_bit1 <= 1'b0;
      board.full_reset(12, 1'b1, 1'b1, 1'b0);
      wait_release();
      osc_run <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (m = 0; m < 8; m++) begin
         @(posedge ref_clk);
         `CHK(slow_clock, osc_in)
      end
      mode_sel_bit0 <= 1'b0;
      board.full_reset(12, 1'b1, 1'b1, 1'b0);
      wait_release();
      highs = 0;
      for (m = 0; m < 4 * HALF; m++) begin
         @(posedge ref_clk);
         highs += int'(slow_clock);
      end
      `CHK(highs, 2 * HALF)
      `CHK(strap, rmc_strap_s'(3'h4))
      rd_chk(ADDR_STAT, 32'h0000_0004);
      rd_chk(ADDR_CTRL, 32'h0000_0004);
      `CHK(periph_clk_en, 1'b1)
      `CHK(ebi_addr_out, 24'hA5_5A5A)
      reg_write(ADDR_CTRL, 32'h0000_0001);
      @(posedge ref_clk);
      `CHK(clock_out_pin, 1'b0)
      reg_write(ADDR_CTRL, 32'h0000_0003);
      @(posedge ref_clk);
      `CHK(clock_out_pin, 1'b1)
      rd_chk(8'h08, 32'h0000_0000);
      fork
         board.full_reset(12, 1'b0, 1'b0, 1'b1);
         begin
            repeat (40) @(posedge ref_clk);
            `CHK(ebi_addr_out, 24'h00_0000)
            `CHK(periph_clk_en, 1'b0)
         end
      join
      wait_release();
      `CHK(strap, rmc_strap_s'(3'h3))
      `CHK(pad_oe_allow, 1'b0)
      `CHK(clock_out_oe, 1'b0)
      rd_chk(ADDR_CTRL, 32'h0000_0004);
      rd_chk(ADDR_STAT, 32'h0000_0018);
      board.set_trst(1'b0);
      @(posedge ref_clk);
      `CHK(rst, rmc_rst_s'(5'h01))
      board.set_trst(1'b1);
      wdt_reset_req <= 1'b1;
      @(posedge ref_clk);
      wdt_reset_req <= 1'b0;
      @(posedge ref_clk);
      `CHK(rst.periph, 1'b1)
      wait_release();
      `CHK(strap, rmc_strap_s'(3'h3))
      `CHK(bscan_extest, 1'b0)
      rd_chk(ADDR_STAT, 32'h0000_0038);
      fork
         board.full_reset(12, 1'b1, 1'b1, 1'b0);
         begin
            @(posedge ref_clk);
            wdt_reset_req <= 1'b1;
            @(posedge ref_clk);
            wdt_reset_req <= 1'b0;
         end
      join
      wait_release();
      `CHK(strap, rmc_strap_s'(3'h4))
      rd_chk(ADDR_STAT, 32'h0000_0004);
      ice_tdo <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK(tdo, 1'b1)
      print_verdict();
   end
endmodule : test_reset_mode_control
